/* hdl/abmi_pkg.sv */
/*
  Shared constants and types of the system bus master port.
  Assumes nothing of its surroundings.
*/
package abmi_pkg;

  localparam int ABMI_AW = 32;
  localparam int ABMI_DW = 32;

  // Transfer type announced for the next transaction
  localparam logic [1:0] ABMI_TRAN_ADDR = 2'h0;
  localparam logic [1:0] ABMI_TRAN_NSEQ = 2'h1;
  localparam logic [1:0] ABMI_TRAN_RSVD = 2'h2;
  localparam logic [1:0] ABMI_TRAN_SEQ  = 2'h3;

  // Transfer size
  localparam logic [1:0] ABMI_SIZE_BYTE = 2'h0;
  localparam logic [1:0] ABMI_SIZE_HALF = 2'h1;
  localparam logic [1:0] ABMI_SIZE_WORD = 2'h2;
  localparam logic [1:0] ABMI_SIZE_RSVD = 2'h3;

  // Burst length code
  localparam logic [1:0] ABMI_BURST_NONE = 2'h0;
  localparam logic [1:0] ABMI_BURST_FOUR = 2'h2;

  // Reset values
  localparam logic [ABMI_AW-1:0] ABMI_ADDR_RST = 32'h0000_0000;
  localparam logic [ABMI_DW-1:0] ABMI_DATA_RST = 32'h0000_0000;
  localparam logic [1:0]         ABMI_PROT_RST = 2'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REQ,
    ST_XFER
  } abmi_state_t;

endpackage

/* hdl/abmi_sync_if.sv */
/*
  Carrier for one bit that crosses into a clock domain.
  Assumes the source drives din from a flip-flop.
*/
`timescale 1ns/10ps
interface abmi_sync_if;
  logic din;
  logic dout;
  modport src (output din, input dout);
  modport dst (input din, output dout);
endinterface

/* hdl/abmi_sync.sv */
/*
  Two flip-flop synchroniser for one level.
  Assumes the reset is asynchronous and low active in the target domain.
*/
`timescale 1ns/10ps
module abmi_sync (
  input wire logic  clk,
  input wire logic  rstN_n,
  abmi_sync_if.dst  s
);

  logic meta_q;
  logic stab_q;

  always_ff @(posedge clk or negedge rstN_n) begin
    if (!rstN_n) begin
      meta_q <= 1'b0;
      stab_q <= 1'b0;
    end else begin
      meta_q <= s.din;
      stab_q <= meta_q;
    end
  end

  assign s.dout = stab_q;

endmodule

/* hdl/abmi_master.sv */
/*
  System bus master port: takes one command at a time on ref_clk, runs the bus
  transfer on the bus clock and returns the answer on ref_clk.
  Assumes the arbiter, decoder and slaves share the bus clock and bus reset.
*/
`timescale 1ns/10ps
module abmi_master
  import abmi_pkg::*;
(
  input  wire logic                       ref_clk,
  input  wire logic                       rst_n,
  input  wire logic                       cmdValid,
  output logic                            cmdReady,
  input  wire logic [abmi_pkg::ABMI_AW-1:0] cmdAddr,
  input  wire logic                       cmdWrite,
  input  wire logic [1:0]                 cmdSize,
  input  wire logic [1:0]                 cmdProt,
  input  wire logic                       cmdLock,
  input  wire logic                       cmdBurst4,
  input  wire logic                       cmdSeq,
  input  wire logic                       cmdMore,
  input  wire logic                       cmdBuffered,
  input  wire logic [abmi_pkg::ABMI_DW-1:0] cmdWdata,
  output logic                            rspValid,
  output logic [abmi_pkg::ABMI_DW-1:0]    rspRdata,
  output logic                            rspError,
  output logic                            testSelected,
  input  wire logic                       bclk,
  input  wire logic                       busRes_n,
  input  wire logic                       agnt,
  output logic                            areq,
  output logic                            nonidleTransferStrobe,
  output logic [abmi_pkg::ABMI_AW-1:0]    baOut,
  output logic                            baOe,
  output logic [1:0]                      btran,
  output logic [1:0]                      bsize,
  output logic [1:0]                      bprot,
  output logic [1:0]                      burst,
  output logic                            blok,
  output logic                            bwriteOut,
  output logic                            bwriteOe,
  input  wire logic [abmi_pkg::ABMI_DW-1:0] bdIn,
  output logic [abmi_pkg::ABMI_DW-1:0]    bdOut,
  output logic                            bdOe,
  input  wire logic                       bwait,
  input  wire logic                       berror,
  input  wire logic                       blast,
  input  wire logic                       dsel,
  output logic                            bufferedWriteFlag,
  output logic                            moreSeqCyclesHint
);

  ////////////////////////////////////////////////////////////////////////////
  // Crossings

  abmi_sync_if reqX ();
  abmi_sync_if ackX ();
  abmi_sync_if selX ();

  abmi_sync u_reqSync (.clk(bclk),    .rstN_n(busRes_n), .s(reqX));
  abmi_sync u_ackSync (.clk(ref_clk), .rstN_n(rst_n),    .s(ackX));
  abmi_sync u_selSync (.clk(ref_clk), .rstN_n(rst_n),    .s(selX));

  ////////////////////////////////////////////////////////////////////////////
  // Command side on ref_clk

  logic                cmdReady_q, cmdReady_d;
  logic                reqTgl_q, reqTgl_d;
  logic                ackSeen_q, ackSeen_d;
  logic                rspValid_q, rspValid_d;
  logic [ABMI_DW-1:0]  rspRdata_q, rspRdata_d;
  logic                rspError_q, rspError_d;
  logic                testSel_q;
  logic [ABMI_AW-1:0]  hAddr_q, hAddr_d;
  logic [ABMI_DW-1:0]  hWdata_q, hWdata_d;
  logic [10:0]         hCtl_q, hCtl_d;
  logic [ABMI_DW-1:0]  bRdata_q, bRdata_d;
  logic                bErr_q, bErr_d;
  logic                ackTgl_q, ackTgl_d;

  assign reqX.din = reqTgl_q;
  assign ackX.din = ackTgl_q;
  assign selX.din = dsel;

  always_comb begin
    cmdReady_d = cmdReady_q;
    reqTgl_d   = reqTgl_q;
    ackSeen_d  = ackX.dout;
    rspValid_d = 1'b0;
    rspRdata_d = rspRdata_q;
    rspError_d = rspError_q;
    hAddr_d    = hAddr_q;
    hWdata_d   = hWdata_q;
    hCtl_d     = hCtl_q;
    if (cmdValid && cmdReady_q) begin
      cmdReady_d = 1'b0;
      reqTgl_d   = ~reqTgl_q;
      hAddr_d    = cmdAddr;
      hWdata_d   = cmdWdata;
      hCtl_d     = {cmdWrite, cmdSize, cmdProt, cmdLock, cmdBurst4, cmdSeq, cmdMore, cmdBuffered, 1'b0};
    end
    if (ackX.dout != ackSeen_q) begin
      cmdReady_d = 1'b1;
      rspValid_d = 1'b1;
      rspRdata_d = bRdata_q;
      rspError_d = bErr_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmdReady_q <= 1'b1;
      reqTgl_q   <= 1'b0;
      ackSeen_q  <= 1'b0;
      rspValid_q <= 1'b0;
      rspRdata_q <= ABMI_DATA_RST;
      rspError_q <= 1'b0;
      testSel_q  <= 1'b0;
      hAddr_q    <= ABMI_ADDR_RST;
      hWdata_q   <= ABMI_DATA_RST;
      hCtl_q     <= 11'h000;
    end else begin
      cmdReady_q <= cmdReady_d;
      reqTgl_q   <= reqTgl_d;
      ackSeen_q  <= ackSeen_d;
      rspValid_q <= rspValid_d;
      rspRdata_q <= rspRdata_d;
      rspError_q <= rspError_d;
      testSel_q  <= selX.dout;
      hAddr_q    <= hAddr_d;
      hWdata_q   <= hWdata_d;
      hCtl_q     <= hCtl_d;
    end
  end

  assign cmdReady     = cmdReady_q;
  assign rspValid     = rspValid_q;
  assign rspRdata     = rspRdata_q;
  assign rspError     = rspError_q;
  assign testSelected = testSel_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus engine on the rising bus clock edge

  abmi_state_t         state_q, state_d;
  logic                reqSeen_q, reqSeen_d;
  logic                areq_q, areq_d;
  logic                strobe_q, strobe_d;
  logic [ABMI_AW-1:0]  ba_q, ba_d;
  logic                baOe_q, baOe_d;
  logic [1:0]          size_q, size_d;
  logic [1:0]          prot_q, prot_d;
  logic [1:0]          burst_q, burst_d;
  logic                lok_q, lok_d;
  logic                wr_q, wr_d;
  logic                seq_q, seq_d;
  logic                more_q, more_d;
  logic                buf_q, buf_d;
  logic                hint_q, hint_d;
  logic                burstEnd_q, burstEnd_d;
  logic [ABMI_DW-1:0]  wdata_q, wdata_d;
  logic                newCmd;
  logic                beatDone;

  assign newCmd   = (reqX.dout != reqSeen_q);
  assign beatDone = (state_q == ST_XFER) && !bwait;

  always_comb begin
    state_d    = state_q;
    reqSeen_d  = reqSeen_q;
    areq_d     = areq_q;
    strobe_d   = strobe_q;
    ba_d       = ba_q;
    baOe_d     = baOe_q;
    size_d     = size_q;
    prot_d     = prot_q;
    burst_d    = burst_q;
    lok_d      = lok_q;
    wr_d       = wr_q;
    seq_d      = seq_q;
    more_d     = more_q;
    buf_d      = buf_q;
    hint_d     = hint_q;
    burstEnd_d = burstEnd_q;
    wdata_d    = wdata_q;
    bRdata_d   = bRdata_q;
    bErr_d     = bErr_q;
    ackTgl_d   = ackTgl_q;
    case (state_q)
      ST_IDLE: begin
        if (newCmd && !dsel) begin
          reqSeen_d = reqX.dout;
          areq_d    = 1'b1;
          ba_d      = hAddr_q;
          wdata_d   = hWdata_q;
          wr_d      = hCtl_q[10];
          size_d    = (hCtl_q[9:8] == ABMI_SIZE_RSVD) ? ABMI_SIZE_WORD : hCtl_q[9:8];
          prot_d    = hCtl_q[7:6];
          lok_d     = hCtl_q[5];
          burst_d   = hCtl_q[4] ? ABMI_BURST_FOUR : ABMI_BURST_NONE;
          seq_d     = hCtl_q[3] && !burstEnd_q;
          more_d    = hCtl_q[2];
          buf_d     = hCtl_q[1] && hCtl_q[10];
          state_d   = ST_REQ;
        end else if (!lok_q) begin
          areq_d = 1'b0;
        end
      end
      ST_REQ: begin
        if (agnt && !bwait && !dsel) begin
          strobe_d = 1'b1;
          baOe_d   = 1'b1;
          hint_d   = more_q && !buf_q;
          state_d  = ST_XFER;
        end
      end
      ST_XFER: begin
        if (beatDone) begin
          strobe_d = 1'b0;
          baOe_d   = 1'b0;
          hint_d   = 1'b0;
          if (berror && blast) begin
            seq_d   = 1'b0;
            state_d = ST_REQ;
          end else begin
            bRdata_d   = bdIn;
            bErr_d     = berror;
            burstEnd_d = blast;
            ackTgl_d   = ~ackTgl_q;
            buf_d      = 1'b0;
            areq_d     = lok_q;
            state_d    = ST_IDLE;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge bclk or negedge busRes_n) begin
    if (!busRes_n) begin
      state_q    <= ST_IDLE;
      reqSeen_q  <= 1'b0;
      areq_q     <= 1'b0;
      strobe_q   <= 1'b0;
      ba_q       <= ABMI_ADDR_RST;
      baOe_q     <= 1'b0;
      size_q     <= ABMI_SIZE_WORD;
      prot_q     <= ABMI_PROT_RST;
      burst_q    <= ABMI_BURST_NONE;
      lok_q      <= 1'b0;
      wr_q       <= 1'b0;
      seq_q      <= 1'b0;
      more_q     <= 1'b0;
      buf_q      <= 1'b0;
      hint_q     <= 1'b0;
      burstEnd_q <= 1'b1;
      wdata_q    <= ABMI_DATA_RST;
      bRdata_q   <= ABMI_DATA_RST;
      bErr_q     <= 1'b0;
      ackTgl_q   <= 1'b0;
    end else begin
      state_q    <= state_d;
      reqSeen_q  <= reqSeen_d;
      areq_q     <= areq_d;
      strobe_q   <= strobe_d;
      ba_q       <= ba_d;
      baOe_q     <= baOe_d;
      size_q     <= size_d;
      prot_q     <= prot_d;
      burst_q    <= burst_d;
      lok_q      <= lok_d;
      wr_q       <= wr_d;
      seq_q      <= seq_d;
      more_q     <= more_d;
      buf_q      <= buf_d;
      hint_q     <= hint_d;
      burstEnd_q <= burstEnd_d;
      wdata_q    <= wdata_d;
      bRdata_q   <= bRdata_d;
      bErr_q     <= bErr_d;
      ackTgl_q   <= ackTgl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Falling bus clock edge: transfer type and write data

  logic [1:0]          tran_q, tran_d;
  logic [ABMI_DW-1:0]  bd_q, bd_d;
  logic                bdOe_q, bdOe_d;

  always_comb begin
    tran_d = ABMI_TRAN_ADDR;
    if (state_q == ST_XFER) begin
      tran_d = seq_q ? ABMI_TRAN_SEQ : ABMI_TRAN_NSEQ;
    end
    bdOe_d = (state_q == ST_XFER) && wr_q;
    bd_d   = bdOe_d ? wdata_q : bd_q;
  end

  always_ff @(negedge bclk or negedge busRes_n) begin
    if (!busRes_n) begin
      tran_q <= ABMI_TRAN_ADDR;
      bd_q   <= ABMI_DATA_RST;
      bdOe_q <= 1'b0;
    end else begin
      tran_q <= tran_d;
      bd_q   <= bd_d;
      bdOe_q <= bdOe_d;
    end
  end

  assign areq                  = areq_q;
  assign nonidleTransferStrobe = strobe_q;
  assign baOut                 = ba_q;
  assign baOe                  = baOe_q;
  assign btran                 = tran_q;
  assign bsize                 = size_q;
  assign bprot                 = prot_q;
  assign burst                 = burst_q;
  assign blok                  = lok_q;
  assign bwriteOut             = wr_q;
  assign bwriteOe              = baOe_q;
  assign bdOut                 = bd_q;
  assign bdOe                  = bdOe_q;
  assign bufferedWriteFlag     = buf_q;
  assign moreSeqCyclesHint     = hint_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_grant_owns;
    @(posedge bclk) disable iff (!busRes_n)
      (state_q == ST_REQ && agnt && !bwait && !dsel) |=> (nonidleTransferStrobe && baOe);
  endproperty
  a_grant_owns: assert property (p_grant_owns) else $error("grant not taken");

  property p_req_raised;
    @(posedge bclk) disable iff (!busRes_n)
      (state_q == ST_IDLE && newCmd && !dsel) |=> areq throughout (state_q == ST_REQ)[*1];
  endproperty
  a_req_raised: assert property (p_req_raised) else $error("request not raised");

  property p_strobe_own;
    @(posedge bclk) disable iff (!busRes_n)
      nonidleTransferStrobe |-> (baOe && state_q == ST_XFER);
  endproperty
  a_strobe_own: assert property (p_strobe_own) else $error("strobe outside transfer");

  property p_codes_legal;
    @(posedge bclk) disable iff (!busRes_n)
      (btran != ABMI_TRAN_RSVD) && (bsize != ABMI_SIZE_RSVD) && (burst[0] == 1'b0);
  endproperty
  a_codes_legal: assert property (p_codes_legal) else $error("reserved code driven");

  property p_wait_holds;
    @(posedge bclk) disable iff (!busRes_n)
      (state_q == ST_XFER && bwait) |=> (state_q == ST_XFER && $stable(baOut) && nonidleTransferStrobe);
  endproperty
  a_wait_holds: assert property (p_wait_holds) else $error("transfer dropped under wait");

  property p_retract_retry;
    @(posedge bclk) disable iff (!busRes_n)
      (beatDone && berror && blast) |=> (state_q == ST_REQ && areq && !baOe && $stable(ackTgl_q));
  endproperty
  a_retract_retry: assert property (p_retract_retry) else $error("retract not retried");

  property p_hint_buffered;
    @(posedge bclk) disable iff (!busRes_n)
      bufferedWriteFlag |-> !moreSeqCyclesHint;
  endproperty
  a_hint_buffered: assert property (p_hint_buffered) else $error("hint during buffered write");

  property p_release_idle;
    @(posedge bclk) disable iff (!busRes_n)
      (state_q != ST_XFER) |-> ##1 (!bdOe || state_q == ST_XFER);
  endproperty
  a_release_idle: assert property (p_release_idle) else $error("data driven without ownership");

  property p_lock_keeps;
    @(posedge bclk) disable iff (!busRes_n)
      (beatDone && !(berror && blast) && blok) |=> areq;
  endproperty
  a_lock_keeps: assert property (p_lock_keeps) else $error("lock released the request");

  property p_answer_ready;
    @(posedge ref_clk) disable iff (!rst_n)
      rspValid |-> cmdReady;
  endproperty
  a_answer_ready: assert property (p_answer_ready) else $error("answer without ready");

  c_grant: cover property (@(posedge bclk) disable iff (!busRes_n) state_q == ST_REQ ##1 state_q == ST_XFER);
  c_retract: cover property (@(posedge bclk) disable iff (!busRes_n) beatDone && berror && blast);
  c_waited: cover property (@(posedge bclk) disable iff (!busRes_n) (state_q == ST_XFER && bwait) ##1 beatDone);
  c_answer: cover property (@(posedge ref_clk) disable iff (!rst_n) rspValid && rspError);

endmodule

/* tb/abmi_bus_model.sv */
/*
  Behavioural arbiter, decoder and slave on the far side of the bus master port.
  Assumes a single master and a bench that resolves the shared data bus.
*/
`timescale 1ns/10ps
module abmi_bus_model (
  input  wire logic        bclk,
  input  wire logic        busRes_n,
  input  wire logic        areq,
  input  wire logic        strobe,
  input  wire logic [31:0] addr,
  input  wire logic        wr,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  waitN,
  input  wire logic        errOn,
  input  wire logic        lastOn,
  input  wire logic        retractOn,
  output logic             agnt,
  output logic [31:0]      rdBus,
  output logic             bwait,
  output logic             berror,
  output logic             blast,
  output logic [31:0]      wrSeen
);
  logic [3:0]  cnt;
  logic        done;
  logic        retrUsed;
  logic [31:0] idlePat;
  logic        resp;
  ////////////////////////////////////////////////////////////////
  // Read data while selected, a toggling pattern once released
  assign rdBus = (strobe && !wr) ? ~addr : idlePat;
  assign resp = strobe && !done && (cnt >= waitN);
  // Answers change on the low phase, sampled by the master on the rise
  always @(negedge bclk or negedge busRes_n) begin
    if (!busRes_n) begin
      agnt <= 1'h0;
      idlePat <= 32'h5a5a_a5a5;
      cnt <= 4'h0;
      bwait <= 1'h0;
      berror <= 1'h0;
      blast <= 1'h0;
    end else begin
      agnt <= areq;
      idlePat <= ~idlePat;
      cnt <= strobe ? cnt + 4'h1 : 4'h0;
      bwait <= strobe && !done && (cnt < waitN);
      berror <= resp && (errOn || (retractOn && !retrUsed));
      blast <= resp && (lastOn || (retractOn && !retrUsed));
    end
  end
  always @(posedge bclk or negedge busRes_n) begin
    if (!busRes_n) begin
      done <= 1'h0;
      retrUsed <= 1'h0;
      wrSeen <= 32'h0;
    end else begin
      if (!strobe) begin
        done <= 1'h0;
      end else if (!bwait && !done) begin
        done <= 1'h1;
        if (wr) wrSeen <= wdata;
        if (berror && blast) retrUsed <= 1'h1;
      end
      if (!retractOn) retrUsed <= 1'h0;
    end
  end
endmodule

/* tb/tb_top.sv */
/*
  Self-checking bench of the bus master port: table of transfers, then retract,
  lock, test select and reset cases. Assumes the bus model in abmi_bus_model.
*/
`timescale 1ns/10ps
module tb_top;
  import abmi_pkg::*;
  typedef struct {
    logic [31:0] a; logic w; logic [1:0] sz; logic [1:0] pr; logic b4;
    logic sq; logic [3:0] wt; logic er; logic ls; logic bf;
  } abmi_row_t;
  logic        ref_clk, rst_n, bclk, busRes_n, cmdValid, cmdReady, cmdWrite, cmdLock, cmdBurst4;
  logic        cmdSeq, cmdMore, cmdBuffered, rspValid, rspError, testSelected, agnt, areq;
  logic        nonidleTransferStrobe, baOe, blok, bwriteOut, bwriteOe, bdOe, bwait, berror, blast;
  logic        dsel, bufferedWriteFlag, moreSeqCyclesHint, errOn, lastOn, retractOn;
  logic [1:0]  cmdSize, cmdProt, btran, bsize, bprot, burst;
  logic [1:0]  snapTran, snapSize, snapProt, snapBurst;
  logic [3:0]  waitN;
  logic [31:0] cmdAddr, cmdWdata, rspRdata, baOut, bdIn, bdOut, mdlRd, wrSeen, snapAddr;
  logic        snapWr, snapHint, snapBuf, prevStb, holdPrev, prevLast;
  logic [31:0] holdAddr;
  int          fails, cmp_count, beats, b0, cycles;
  abmi_row_t   rows[5] = '{
    '{32'h0000_1000, 1'h0, 2'h0, 2'h0, 1'h0, 1'h0, 4'h0, 1'h0, 1'h0, 1'h0},
    '{32'h0000_2002, 1'h1, 2'h1, 2'h1, 1'h1, 1'h1, 4'h2, 1'h0, 1'h0, 1'h1},
    '{32'h0000_3004, 1'h0, 2'h2, 2'h2, 1'h0, 1'h0, 4'h1, 1'h1, 1'h0, 1'h0},
    '{32'h0000_4008, 1'h1, 2'h3, 2'h3, 1'h1, 1'h1, 4'h0, 1'h0, 1'h1, 1'h0},
    '{32'h0000_500c, 1'h0, 2'h2, 2'h1, 1'h0, 1'h1, 4'h3, 1'h0, 1'h0, 1'h0}};
  ////////////////////////////////////////////////////////////////
  abmi_master abmi_master_inst (.ref_clk, .rst_n, .cmdValid, .cmdReady, .cmdAddr, .cmdWrite, .cmdSize,
    .cmdProt, .cmdLock, .cmdBurst4, .cmdSeq, .cmdMore, .cmdBuffered, .cmdWdata, .rspValid, .rspRdata,
    .rspError, .testSelected, .bclk, .busRes_n, .agnt, .areq, .nonidleTransferStrobe, .baOut, .baOe,
    .btran, .bsize, .bprot, .burst, .blok, .bwriteOut, .bwriteOe, .bdIn, .bdOut, .bdOe, .bwait,
    .berror, .blast, .dsel, .bufferedWriteFlag, .moreSeqCyclesHint);
  abmi_bus_model abmi_bus_model_inst (.bclk, .busRes_n, .areq, .strobe(nonidleTransferStrobe),
    .addr(baOut), .wr(bwriteOut), .wdata(bdIn), .waitN, .errOn, .lastOn, .retractOn, .agnt,
    .rdBus(mdlRd), .bwait, .berror, .blast, .wrSeen);
  assign bdIn = bdOe ? bdOut : mdlRd;
  ////////////////////////////////////////////////////////////////
  initial ref_clk = 1'h0;
  always #4 ref_clk = ~ref_clk;
  initial bclk = 1'h0;
  always #3 bclk = ~bclk;
  task automatic chkb(input bit ok, input string msg);
    cmp_count++;
    if (!ok) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic cmpv(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic ck(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic send(input abmi_row_t r, input logic lk);
    int n;
    n = 0;
    while (cmdReady !== 1'h1 && n < 500) begin
      ck(1);
      n++;
    end
    {cmdAddr, cmdWrite, cmdSize, cmdProt, cmdBurst4, cmdSeq, cmdMore} = {r.a, r.w, r.sz, r.pr, r.b4, r.sq, r.sq};
    {cmdBuffered, cmdLock, cmdWdata} = {r.bf, lk, r.a[15:0], r.a[31:16]};
    {waitN, errOn, lastOn} = {r.wt, r.er, r.ls};
    cmdValid = 1'h1;
    ck(1);
    cmdValid = 1'h0;
  endtask
  task automatic waitRsp();
    int n;
    n = 0;
    while (rspValid !== 1'h1 && n < 400) begin
      ck(1);
      n++;
    end
    chkb(rspValid === 1'h1, "no answer to command");
  endtask
  task automatic chkRst();
    chkb(cmdReady === 1'h1 && rspValid === 1'h0 && areq === 1'h0, "user side not at reset");
    chkb(baOe === 1'h0 && bdOe === 1'h0 && btran === ABMI_TRAN_ADDR && bsize === ABMI_SIZE_WORD,
      "bus side not at reset");
  endtask
  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Bus watcher: snapshot of each beat and standing checks on the wire
  always @(posedge bclk) begin
    if (nonidleTransferStrobe === 1'h1) begin
      {snapTran, snapSize, snapProt, snapBurst, snapWr, snapAddr} <= {btran, bsize, bprot, burst, bwriteOut, baOut};
      {snapHint, snapBuf} <= {moreSeqCyclesHint, bufferedWriteFlag};
      chkb(baOe === 1'h1 && areq === 1'h1 && agnt === 1'h1, "beat without ownership");
      chkb(bwriteOe === 1'h1, "direction not driven in beat");
    end
    if (nonidleTransferStrobe === 1'h1 && prevStb !== 1'h1) beats <= beats + 1;
    prevStb <= nonidleTransferStrobe;
    if (holdPrev && busRes_n === 1'h1) chkb(baOut === holdAddr, "address moved during wait");
    holdPrev <= nonidleTransferStrobe === 1'h1 && bwait === 1'h1;
    holdAddr <= baOut;
    if (busRes_n === 1'h1) begin
      chkb(btran !== ABMI_TRAN_RSVD && bsize !== ABMI_SIZE_RSVD, "reserved code");
      chkb(burst[0] === 1'h0, "reserved burst code");
      if (bdOe === 1'h1) chkb(baOe === 1'h1 && bwriteOut === 1'h1, "data driven outside write");
      if (bufferedWriteFlag === 1'h1) chkb(moreSeqCyclesHint === 1'h0, "hint during buffered write");
    end
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      give_verdict;
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    {rst_n, busRes_n, cmdValid, cmdWrite, cmdLock, cmdBurst4, cmdSeq, cmdMore, cmdBuffered} = 9'h0;
    {cmdSize, cmdProt, cmdAddr, cmdWdata, dsel, errOn, lastOn, retractOn, waitN} = 76'h0;
    {fails, cmp_count, beats, cycles, prevLast, holdPrev} = 0;
    ck(3);
    chkRst();
    busRes_n = 1'h1;
    ck(3);
    rst_n = 1'h1;
    foreach (rows[i]) begin
      b0 = beats;
      send(rows[i], 1'h0);
      waitRsp();
      cmpv(rspError, rows[i].er, "error flag");
      cmpv(rows[i].w ? wrSeen : rspRdata, rows[i].w ? {rows[i].a[15:0], rows[i].a[31:16]} : ~rows[i].a,
        "data");
      cmpv(snapAddr, rows[i].a, "address");
      cmpv(snapWr, rows[i].w, "direction");
      cmpv(snapHint, rows[i].sq && !(rows[i].bf && rows[i].w), "more hint");
      cmpv(snapBuf, rows[i].bf && rows[i].w, "buffered flag");
      cmpv(snapSize, rows[i].sz == 2'h3 ? ABMI_SIZE_WORD : rows[i].sz, "size");
      cmpv(snapProt, rows[i].pr, "protection");
      cmpv(snapBurst, rows[i].b4 ? ABMI_BURST_FOUR : ABMI_BURST_NONE, "burst code");
      cmpv(snapTran, rows[i].sq && !prevLast ? ABMI_TRAN_SEQ : ABMI_TRAN_NSEQ, "transfer type");
      cmpv(32'(beats - b0), 32'h1, "beats per command");
      prevLast = rows[i].ls;
    end
    // Retract: one answer, two beats, no error
    retractOn = 1'h1;
    b0 = beats;
    send(rows[1], 1'h0);
    waitRsp();
    cmpv(rspError, 1'h0, "retract answer");
    cmpv(32'(beats - b0), 32'h2, "retract retry");
    retractOn = 1'h0;
    // Lock keeps the request up until the following transfer ends
    send(rows[0], 1'h1);
    waitRsp();
    ck(10);
    chkb(areq === 1'h1 && blok === 1'h1, "request dropped after locked beat");
    send(rows[2], 1'h0);
    waitRsp();
    ck(10);
    chkb(areq === 1'h0, "request held without need");
    // Test select parks the master
    dsel = 1'h1;
    b0 = beats;
    send(rows[0], 1'h0);
    ck(40);
    chkb(testSelected === 1'h1, "test select not seen");
    cmpv(32'(beats - b0), 32'h0, "beat while test selected");
    dsel = 1'h0;
    waitRsp();
    cmpv(rspRdata, ~rows[0].a, "read after test select");
    // Reset in mid transfer, then recovery
    send(rows[4], 1'h0);
    ck(3);
    {rst_n, busRes_n} = 2'h0;
    ck(3);
    chkRst();
    busRes_n = 1'h1;
    ck(3);
    rst_n = 1'h1;
    send(rows[3], 1'h0);
    waitRsp();
    cmpv(wrSeen, {rows[3].a[15:0], rows[3].a[31:16]}, "write after reset");
    give_verdict;
  end
endmodule
